/* chip_far_side.sv */
/*
 converter chip model: readback levels and scan capture
 assumes scan pins from the handler
*/
`timescale 1ns/10ps
`default_nettype none
module chip_far_side #(
    parameter logic [31:0] ID_BASE = 32'h1357_2460 // arbitrary value
) (
    // scan pins
    input wire logic          scan_clk,
    input wire logic          scan_data,
    input wire logic [3:0]    scan_sel,
    // readback
    output logic [3:0][31:0]  chip_id,
    output logic [3:0][10:0]  chip_err,
    output logic [3:0]        chip_lock,
    output logic [3:0][61:0]  chip_status,
    output logic [3:0][646:0] img
);
    initial img = '0;
    always @(posedge scan_clk)
        for (int i = 0; i < 4; i++)
            if (scan_sel[i]) img[i] <= {scan_data, img[i][646:1]};
    always_comb begin
        chip_lock = 4'h5;
        for (int i = 0; i < 4; i++) begin
            chip_id[i] = ID_BASE | 32'(i);
            chip_err[i] = 11'h2A5 ^ 11'(i);
            chip_status[i] = {14'h1234 ^ 14'(i), 48'h5678_9ABC_DEF0};
        end
    end
endmodule
`default_nettype wire

/* chip_word_sel.sv */
/*
 picks the 16-bit answer word from the converter chips' readback
 assumes chip inputs are synchronous to ref_clk
*/
`timescale 1ns/10ps
`default_nettype none
`include "tdc_opc_map.svh"
module chip_word_sel (
    // selection
    input  wire logic [7:0]        op,
    input  wire logic [1:0]        chip,
    input  wire logic [2:0]        idx,
    // chip readback
    input  wire logic [3:0][31:0]  chip_id,
    input  wire logic [3:0][10:0]  chip_err,
    input  wire logic [3:0]        chip_lock,
    input  wire logic [3:0][61:0]  chip_status,
    // answer
    output logic      [15:0]       word
);
    logic [63:0] stat;
    always_comb begin
        stat = {2'h0, chip_status[chip]};
        word = 16'h0000;
        unique case (op)
            `OP_RD_ID:   word = idx[0] ? chip_id[chip][15:0] : chip_id[chip][31:16];
            `OP_RD_ERR:  word = {5'h00, chip_err[chip]};
            `OP_RD_LOCK: word = {15'h0000, chip_lock[chip]};
            `OP_RD_STAT: word = stat[idx[1:0]*16 +: 16];
            default:     word = 16'h0000;
        endcase
    end
endmodule
`default_nettype wire

/* setup_loader.sv */
/*
 shifts the setup scan path with its parity bit into selected chips
 assumes setup_bits stay stable while busy
*/
`timescale 1ns/10ps
`default_nettype none
`include "tdc_opc_map.svh"
module setup_loader (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    // request
    input  wire logic          start,
    input  wire logic [3:0]    chip_mask,
    input  wire logic [645:0]  setup_bits,
    // scan pins
    output wire logic          scan_clk,
    output wire logic          scan_data,
    output wire logic [3:0]    scan_sel,
    output wire logic          scan_update,
    output wire logic          busy
);
    typedef struct packed {
        logic       busy;
        logic       phase;
        logic [2:0] div;
        logic [9:0] pos;
        logic       clk;
        logic       data;
        logic [3:0] sel;
        logic       update;
    } ld_t;
    ld_t q;
    ld_t n;
    logic [646:0] full;
    always_comb begin
        n = q;
        n.update = 1'b0;
        full = {^setup_bits, setup_bits};
        if (!q.busy) begin
            if (start) begin
                n.busy = 1'b1;
                n.sel = chip_mask;
                n.div = 3'h0;
                n.phase = 1'b0;
                n.pos = 10'h000;
                n.data = full[0];
            end
        end else if (q.div == 3'(`SCAN_HALF_CYCLES - 1)) begin
            n.div = 3'h0;
            n.phase = ~q.phase;
            n.clk = ~q.phase;
            if (q.phase) begin
                if (q.pos == 10'(`SETUP_BITS)) begin
                    n.busy = 1'b0;
                    n.sel = 4'h0;
                    n.update = 1'b1;
                end else begin
                    n.pos = q.pos + 10'h001;
                    n.data = full[q.pos + 10'h001];
                end
            end
        end else begin
            n.div = q.div + 3'h1;
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
    assign scan_clk = q.clk;
    assign scan_data = q.data;
    assign scan_sel = q.sel;
    assign scan_update = q.update;
    assign busy = q.busy;
endmodule
`default_nettype wire

/* tdc_adjust_and_setup_opcodes_test.sv */
/*
 bench for the opcode handler over axi4-lite
 assumes chip_far_side on the chip pins
*/
`timescale 1ns/10ps
`default_nettype none
`include "tdc_opc_map.svh"
module tdc_adjust_and_setup_opcodes_test;
    logic ref_clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, scan_clk, scan_data, scan_update, pll_dll_reset;
    logic [1:0] bresp, rresp;
    logic [3:0] scan_sel, chip_lock;
    logic [10:0] coarse_offset;
    logic [4:0] fine_offset;
    logic [3:0][31:0] chip_id;
    logic [3:0][10:0] chip_err;
    logic [3:0][61:0] chip_status;
    logic [3:0][646:0] img;
    int num_errors = 0, n_tests = 0;
    always #20 ref_clk = ~ref_clk;
    tdc_opc_handler u_dut (.ref_clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .chip_id, .chip_err, .chip_lock, .chip_status, .scan_clk, .scan_data, .scan_sel,
        .scan_update, .pll_dll_reset, .coarse_offset, .fine_offset);
    chip_far_side u_far (.scan_clk, .scan_data, .scan_sel, .chip_id, .chip_err, .chip_lock,
        .chip_status, .img);
    // ----------
    // tasks
    // ----------
    task chk(input logic [646:0] s, input logic [646:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, s, e);
        end
    endtask
    task axw(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 200);
        bready <= 1'b1;
        @(posedge ref_clk);
        bready <= 1'b0;
        chk({bvalid, bresp}, {1'b1, er});
    endtask
    task axr(input logic [11:0] a, input logic [15:0] ed, input logic [1:0] er, input logic [15:0] m);
        int n;
        n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 200);
        rready <= 1'b1;
        @(posedge ref_clk);
        rready <= 1'b0;
        chk({rvalid, rresp, rdata[15:0] & m}, {1'b1, er, ed & m});
    endtask
    task cmd(input logic [15:0] d);
        axw(`CMD_PORT_OFS, d, `RESP_OKAY);
    endtask
    task rd(input logic [15:0] ed, input logic [15:0] m);
        axr(`CMD_PORT_OFS, ed, `RESP_OKAY, m);
    endtask
    task wait_load;
        int n;
        n = 0;
        while (scan_sel === 4'h0 && n < 50) begin @(posedge ref_clk); n++; end
        chk(|scan_sel, 1'b1);
        axw(`CMD_PORT_OFS, 16'h6100, `RESP_SLVERR);
        while (scan_sel !== 4'h0 && n < 9000) begin @(posedge ref_clk); n++; end
        chk(scan_sel, 4'h0);
    endtask
    function automatic logic [646:0] mk(input logic [15:0] w0, input logic [15:0] w39);
        logic [646:0] v;
        v = '0;
        v[15:0] = w0;
        v[639:624] = w39;
        v[646] = ^v[645:0];
        return v;
    endfunction
    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #2400000;
        num_errors++;
        wrap_up;
    end
    // ----------
    // tests
    // ----------
    initial begin
        logic [63:0] st;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        cmd(16'h50FF);
        axw(`CMD_PORT_OFS, 16'hFBA5, `RESP_OKAY);
        chk(coarse_offset, 11'h3A5);
        axw(`CMD_PORT_OFS, 16'hFFF3, `RESP_OKAY);
        chk(fine_offset, 5'h13);
        cmd(16'h5100);
        axw(`CMD_PORT_OFS, 16'h6100, `RESP_SLVERR);
        rd(16'h03A5, 16'h07FF);
        rd(16'h0013, 16'h001F);
        axr(`CMD_PORT_OFS, 16'h0, `RESP_SLVERR, 16'hFFFF);
        $display("offsets done");
        for (int c = 0; c < 128; c += 127) begin cmd({8'h52, 8'(c)}); cmd(16'hFF5A + 16'(c)); end
        for (int c = 0; c < 128; c += 127) begin cmd({8'h53, 8'(c)}); rd(16'h5A + 16'(c), 16'h00FF); end
        for (int k = 0; k < 3; k++) cmd({8'h54 + 8'(k), 8'h00});
        axr(`STATUS_OFS, 16'h0, `RESP_OKAY, 16'h000F);
        chk(coarse_offset, 11'h3A5);
        for (int c = 0; c < 4; c++) begin
            cmd({12'h600, 4'(c)});
            rd(chip_id[c][31:16], 16'hFFFF);
            rd(chip_id[c][15:0], 16'hFFFF);
        end
        cmd(16'h61AA);
        rd({8'h00, `FW_REV}, 16'h00FF);
        cmd(16'h6200);
        repeat (2) @(posedge ref_clk);
        chk(pll_dll_reset, 1'b1);
        axr(`STATUS_OFS, 16'h0, `RESP_OKAY, 16'h000F);
        $display("ident done");
        cmd(16'h7027);
        cmd(16'h8000);
        cmd(16'h7000);
        cmd(16'hA5A5);
        cmd(16'h7028);
        cmd(16'h0040);
        chk(img[0], '0);
        cmd(16'h7127);
        rd(16'h8000, 16'hFFFF);
        cmd(16'h7200);
        wait_load;
        for (int c = 0; c < 4; c++) chk(img[c], mk(16'hA5A5, 16'h8000));
        cmd(16'h7000);
        cmd(16'h0F0F);
        cmd(16'h7701);
        wait_load;
        chk(img[1], mk(16'h0F0F, 16'h8000));
        chk(img[0], mk(16'hA5A5, 16'h8000));
        cmd(16'h7300);
        wait_load;
        chk(img[2], mk(`SETUP_DFLT_WORD, `SETUP_DFLT_WORD));
        $display("setup done");
        st = {2'b00, chip_status[2]};
        cmd(16'h7402);
        rd({5'h0, chip_err[2]}, 16'h07FF);
        cmd(16'h7502);
        rd({15'h0, chip_lock[2]}, 16'h0001);
        cmd(16'h7602);
        for (int k = 0; k < 4; k++) rd(st[16*k +: 16], 16'hFFFF);
        axw(12'h010, 16'h1234, `RESP_DECERR);
        axr(12'h010, 16'h0, `RESP_DECERR, 16'hFFFF);
        axw(`STATUS_OFS, 16'h1234, `RESP_SLVERR);
        $display("status done");
        wrap_up;
    end
endmodule
`default_nettype wire

/* tdc_opc_chk.sv */
/*
 concurrent checks on the opcode handler ports
 assumes one clock, reset active low
*/
`timescale 1ns/10ps
`default_nettype none
module tdc_opc_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // bus
    input wire logic        awready,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    // chip control
    input wire logic        scan_clk,
    input wire logic        scan_data,
    input wire logic [3:0]  scan_sel,
    input wire logic        scan_update,
    input wire logic        pll_dll_reset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_no_aw; bvalid |-> !awready && !wready; endproperty
    a_no_aw: assert property (p_no_aw) else $error("write taken early");
    property p_r_ans; arvalid && arready |=> rvalid; endproperty
    a_r_ans: assert property (p_r_ans) else $error("read late");
    property p_r_zero; rvalid && rresp != 2'h0 |-> rdata == 32'h0; endproperty
    a_r_zero: assert property (p_r_zero) else $error("refused read data");
    property p_pll_len; $fell(pll_dll_reset) |-> $past(pll_dll_reset, 25) && !$past(pll_dll_reset, 26); endproperty
    a_pll_len: assert property (p_pll_len) else $error("pll pulse length");
    property p_sel_hold; scan_sel != 4'h0 |=> scan_sel == $past(scan_sel) || scan_sel == 4'h0; endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved");
    property p_dat; $rose(scan_clk) |-> $stable(scan_data); endproperty
    a_dat: assert property (p_dat) else $error("data moved at clock");
    property p_upd; scan_update |-> $past(scan_sel) != 4'h0 ##1 !scan_update; endproperty
    a_upd: assert property (p_upd) else $error("update pulse");
    c_load: cover property (scan_update);
    c_pll: cover property ($rose(pll_dll_reset));
    c_refuse: cover property (bvalid && bresp == 2'h2);
endmodule
bind tdc_opc_handler tdc_opc_chk u_chk (.ref_clk, .rstn, .awready, .wready, .bvalid, .bready, .bresp,
    .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .scan_clk, .scan_data, .scan_sel,
    .scan_update, .pll_dll_reset);
`default_nettype wire

/* tdc_opc_handler.sv */
/*
 opcode handler for offset adjust, identification, pll/dll reset and
 setup scan path commands, reached through an axi4-lite slave
 assumes one clock, async active-low reset, chip readback synchronous
*/
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tdc_opc_map.svh"

// Behaviour
// - set-global-offset takes two writes: 11-bit coarse, then 5-bit fine offset.
// - read-global-offset returns two words: coarse offset first, then fine.
// - opcode expecting data blocks further commands until all transfers done.
// - channel adjust opcode: channel in low byte, one write, low 8 bits used.
// - read channel adjust returns one word, offset in low 8 bits.
// - rc adjust set, read and save opcodes do nothing.
// - chip id read selects chip by low bits, returns id over reads.
// - firmware revision read returns one word, revision in low byte.
// - reset opcode pulses pll and dll reset, no data transfer.
// - shadow setup array of 16-bit words; bit 639 is word 39 bit 15.
// - handler computes scan parity itself; host never sets it.
// - write setup word stores into shadow only, index up to 0x28.
// - read setup word returns one shadow word.
// - load opcode shifts shadow setup into all chips.
// - reload default restores default setup and loads all chips.
// - read errors returns chip's 11 error bits.
// - read lock returns chip's dll lock in bit 0.
// - read chip status returns 62 bits over four reads.
// - per-chip load shifts shadow into chip n only.
module tdc_opc_handler
    import tdc_opc_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // axi4-lite write address
    input  wire logic [11:0]       awaddr,
    input  wire logic              awvalid,
    output wire logic              awready,
    // axi4-lite write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output wire logic              wready,
    // axi4-lite write response
    output wire logic [1:0]        bresp,
    output wire logic              bvalid,
    input  wire logic              bready,
    // axi4-lite read address
    input  wire logic [11:0]       araddr,
    input  wire logic              arvalid,
    output wire logic              arready,
    // axi4-lite read data
    output wire logic [31:0]       rdata,
    output wire logic [1:0]        rresp,
    output wire logic              rvalid,
    input  wire logic              rready,
    // converter chip readback
    input  wire logic [3:0][31:0]  chip_id,
    input  wire logic [3:0][10:0]  chip_err,
    input  wire logic [3:0]        chip_lock,
    input  wire logic [3:0][61:0]  chip_status,
    // converter chip control
    output wire logic              scan_clk,
    output wire logic              scan_data,
    output wire logic [3:0]        scan_sel,
    output wire logic              scan_update,
    output wire logic              pll_dll_reset,
    output wire logic [10:0]       coarse_offset,
    output wire logic [4:0]        fine_offset
);
    import tdc_opc_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              arready;
        logic              bvalid;
        logic              rvalid;
        logic [1:0]        bresp;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic              aw_held;
        logic              w_held;
        logic [11:0]       waddr;
        logic [15:0]       wword;
        logic [1:0]        wlanes;
        hstate_t           hs;
        logic [7:0]        op;
        logic [7:0]        par;
        logic [2:0]        left;
        logic [2:0]        idx;
        logic [10:0]       coarse;
        logic [4:0]        fine;
        logic [127:0][7:0] adj;
        logic [40:0][15:0] shadow;
        logic [4:0]        pll_cnt;
        logic              pll_rst;
        logic              load_go;
        logic              load_seen;
        logic [3:0]        load_mask;
    } hall_t;

    hall_t       q;
    hall_t       next_q;
    logic [15:0] chip_word;
    logic [15:0] rd_word;
    logic [15:0] status_word;
    logic        load_busy;
    logic [3:0]  xfer;
    logic [655:0] shadow_bits;

    // ----------------------------------------
    // decode functions
    // ----------------------------------------
    function automatic reg_sel_t reg_sel(input logic [11:0] a);
        if (a == `CMD_PORT_OFS) begin
            return SEL_CMD;
        end else if (a == `STATUS_OFS) begin
            return SEL_STAT;
        end
        return SEL_NONE;
    endfunction

    // returns {is_read, transfer count}
    function automatic logic [3:0] xfer_of(input logic [7:0] op);
        unique case (op)
            `OP_SET_GOFS:  return 4'h2;
            `OP_RD_GOFS:   return 4'hA;
            `OP_SET_CHADJ: return 4'h1;
            `OP_RD_CHADJ:  return 4'h9;
            `OP_RD_ID:     return 4'hA;
            `OP_RD_FWREV:  return 4'h9;
            `OP_WR_SETUP:  return 4'h1;
            `OP_RD_SETUP:  return 4'h9;
            `OP_RD_ERR:    return 4'h9;
            `OP_RD_LOCK:   return 4'h9;
            `OP_RD_STAT:   return 4'hC;
            default:       return 4'h0;
        endcase
    endfunction

    // ----------------------------------------
    // chip readback and scan loader
    // ----------------------------------------
    chip_word_sel u_sel (
        .op          (q.op),
        .chip        (q.par[1:0]),
        .idx         (q.idx),
        .chip_id     (chip_id),
        .chip_err    (chip_err),
        .chip_lock   (chip_lock),
        .chip_status (chip_status),
        .word        (chip_word)
    );

    assign shadow_bits = q.shadow;

    setup_loader u_load (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .start       (q.load_go),
        .chip_mask   (q.load_mask),
        .setup_bits  (shadow_bits[`SETUP_BITS-1:0]),
        .scan_clk    (scan_clk),
        .scan_data   (scan_data),
        .scan_sel    (scan_sel),
        .scan_update (scan_update),
        .busy        (load_busy)
    );

    // ----------------------------------------
    // answer words
    // ----------------------------------------
    always_comb begin
        rd_word = 16'h0000;
        unique case (q.op)
            `OP_RD_GOFS:  rd_word = q.idx[0] ? {11'h000, q.fine} : {5'h00, q.coarse};
            `OP_RD_CHADJ: rd_word = {8'h00, q.adj[q.par[6:0]]};
            `OP_RD_FWREV: rd_word = {8'h00, `FW_REV};
            `OP_RD_SETUP: rd_word = (q.par <= `SETUP_LAST_IDX) ? q.shadow[q.par[5:0]] : 16'h0000;
            default:      rd_word = chip_word;
        endcase
    end

    always_comb begin
        status_word = 16'h0000;
        status_word[`STAT_BUSY_BIT] = (q.hs != H_IDLE);
        status_word[`STAT_WR_BIT] = (q.hs == H_WAIT_WR);
        status_word[`STAT_RD_BIT] = (q.hs == H_WAIT_RD);
        status_word[`STAT_LOAD_BIT] = (q.hs == H_LOAD);
        status_word[`STAT_LEFT_LSB +: 3] = q.left;
        status_word[`STAT_OP_LSB +: 8] = q.op;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_q = q;
        next_q.load_go = 1'b0;
        xfer = 4'h0;
        if (q.pll_cnt != 5'h00) begin
            next_q.pll_cnt = q.pll_cnt - 5'h01;
        end
        next_q.pll_rst = (next_q.pll_cnt != 5'h00);
        if (q.bvalid && bready) begin
            next_q.bvalid = 1'b0;
        end
        if (q.rvalid && rready) begin
            next_q.rvalid = 1'b0;
        end
        if (awvalid && q.awready) begin
            next_q.aw_held = 1'b1;
            next_q.waddr = awaddr;
        end
        if (wvalid && q.wready) begin
            next_q.w_held = 1'b1;
            next_q.wword = wdata[15:0];
            next_q.wlanes = wstrb[1:0];
        end
        if (q.hs == H_LOAD) begin
            if (load_busy) begin
                next_q.load_seen = 1'b1;
            end else if (q.load_seen) begin
                next_q.hs = H_IDLE;
            end
        end
        // write execution once address and data are both held
        if (q.aw_held && q.w_held && !q.bvalid) begin
            next_q.aw_held = 1'b0;
            next_q.w_held = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = `RESP_OKAY;
            if (reg_sel(q.waddr) == SEL_NONE) begin
                next_q.bresp = `RESP_DECERR;
            end else if (reg_sel(q.waddr) == SEL_STAT || q.wlanes != 2'h3) begin
                next_q.bresp = `RESP_SLVERR;
            end else if (q.hs == H_IDLE) begin
                next_q.op = q.wword[15:8];
                next_q.par = q.wword[7:0];
                next_q.idx = 3'h0;
                xfer = xfer_of(q.wword[15:8]);
                next_q.left = xfer[2:0];
                if (xfer[2:0] != 3'h0) begin
                    next_q.hs = xfer[3] ? H_WAIT_RD : H_WAIT_WR;
                end
                unique case (q.wword[15:8])
                    `OP_PLL_RST: begin
                        next_q.pll_cnt = 5'(`PLL_RST_CYCLES);
                        next_q.pll_rst = 1'b1;
                    end
                    `OP_LOAD_ALL: begin
                        next_q.hs = H_LOAD;
                        next_q.load_mask = 4'hF;
                    end
                    `OP_LOAD_DFLT: begin
                        next_q.hs = H_LOAD;
                        next_q.load_mask = 4'hF;
                        next_q.shadow = {41{`SETUP_DFLT_WORD}};
                    end
                    `OP_LOAD_ONE: begin
                        next_q.hs = H_LOAD;
                        next_q.load_mask = 4'h1 << q.wword[1:0];
                    end
                    default: begin
                    end
                endcase
                next_q.load_go = (next_q.hs == H_LOAD);
                next_q.load_seen = 1'b0;
            end else if (q.hs == H_WAIT_WR) begin
                unique case (q.op)
                    `OP_SET_GOFS: begin
                        if (q.idx == 3'h0) begin
                            next_q.coarse = q.wword[10:0];
                        end else begin
                            next_q.fine = q.wword[4:0];
                        end
                    end
                    `OP_SET_CHADJ: next_q.adj[q.par[6:0]] = q.wword[7:0];
                    `OP_WR_SETUP: begin
                        if (q.par <= `SETUP_LAST_IDX) begin
                            next_q.shadow[q.par[5:0]] = q.wword;
                        end
                    end
                    default: begin
                    end
                endcase
                next_q.idx = q.idx + 3'h1;
                next_q.left = q.left - 3'h1;
                if (q.left == 3'h1) begin
                    next_q.hs = H_IDLE;
                end
            end else begin
                next_q.bresp = `RESP_SLVERR;
            end
        end
        // read execution, answered at the next edge
        if (arvalid && q.arready) begin
            next_q.rvalid = 1'b1;
            next_q.rresp = `RESP_OKAY;
            next_q.rdata = 32'h0000_0000;
            unique case (reg_sel(araddr))
                SEL_CMD: begin
                    if (q.hs == H_WAIT_RD) begin
                        next_q.rdata = {16'h0000, rd_word};
                        next_q.idx = q.idx + 3'h1;
                        next_q.left = q.left - 3'h1;
                        if (q.left == 3'h1) begin
                            next_q.hs = H_IDLE;
                        end
                    end else begin
                        next_q.rresp = `RESP_SLVERR;
                    end
                end
                SEL_STAT: next_q.rdata = {16'h0000, status_word};
                default:  next_q.rresp = `RESP_DECERR;
            endcase
        end
        next_q.awready = !next_q.aw_held && !next_q.bvalid;
        next_q.wready = !next_q.w_held && !next_q.bvalid;
        next_q.arready = !next_q.rvalid;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign arready = q.arready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata;
    assign pll_dll_reset = q.pll_rst;
    assign coarse_offset = q.coarse;
    assign fine_offset = q.fine;
endmodule
`default_nettype wire

/* tdc_opc_map.svh */
/*
 offsets, opcodes, field positions, reset values and timing counts
 of the opcode handler; included by the handler, chip_word_sel, setup_loader and the bench
*/
`ifndef TDC_OPC_MAP_SVH
`define TDC_OPC_MAP_SVH
`define CMD_PORT_OFS      12'h000
`define STATUS_OFS        12'h004
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define RESP_DECERR       2'h3
`define OP_SET_GOFS       8'h50
`define OP_RD_GOFS        8'h51
`define OP_SET_CHADJ      8'h52
`define OP_RD_CHADJ       8'h53
`define OP_RD_ID          8'h60
`define OP_RD_FWREV       8'h61
`define OP_PLL_RST        8'h62
`define OP_WR_SETUP       8'h70
`define OP_RD_SETUP       8'h71
`define OP_LOAD_ALL       8'h72
`define OP_LOAD_DFLT      8'h73
`define OP_RD_ERR         8'h74
`define OP_RD_LOCK        8'h75
`define OP_RD_STAT        8'h76
`define OP_LOAD_ONE       8'h77
`define SETUP_LAST_IDX    8'h28
`define SETUP_BITS        646
`define SETUP_DFLT_WORD   16'h0000
`define FW_REV            8'h01
`define STAT_BUSY_BIT     0
`define STAT_WR_BIT       1
`define STAT_RD_BIT       2
`define STAT_LOAD_BIT     3
`define STAT_LEFT_LSB     4
`define STAT_OP_LSB       8
`define CLK_PERIOD_NS     40
`define SCAN_HALF_NS      200
`define SCAN_HALF_CYCLES  ((`SCAN_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_RST_NS        1000
`define PLL_RST_CYCLES    ((`PLL_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* tdc_opc_pkg.sv */
/*
 types of the opcode handler
 assumes nothing of its surroundings
*/
`default_nettype none
package tdc_opc_pkg;
    typedef enum logic [1:0] {
        H_IDLE    = 2'h0,
        H_WAIT_WR = 2'h1,
        H_WAIT_RD = 2'h3,
        H_LOAD    = 2'h2
    } hstate_t;
    typedef enum logic [1:0] {
        SEL_CMD  = 2'h0,
        SEL_STAT = 2'h1,
        SEL_NONE = 2'h2
    } reg_sel_t;
endpackage
`default_nettype wire
